//--- core/cpa_map.svh
// Register offsets, field positions, reset values and limits for the
// cam phase alignment control block.
// Assumes inclusion by bare name from design files only.
`ifndef CPA_MAP_SVH
`define CPA_MAP_SVH

// ==========================================================================
// Register offsets and reset values
`define CPA_OFS_SOURCE 16'h0298
`define CPA_OFS_MASKING 16'h029A
`define CPA_RST_SOURCE 16'h0000
`define CPA_RST_MASKING 16'h0000
`define CPA_RST_TARGET 32'h00000000

// ==========================================================================
// Source setting fields
`define CPA_BIT_ENABLE 0
`define CPA_BIT_LAUNCH 1
`define CPA_BIT_FILM 2
`define CPA_FILT_LSB 4
`define CPA_FILT_MSB 7
`define CPA_PATH_LSB 8
`define CPA_PATH_MSB 15

// ==========================================================================
// Operation setting fields and limits
`define CPA_SLOT_LSB 8
`define CPA_SLOT_MSB 13
`define CPA_PATH_FULL 8'h64
`define CPA_DIV_CYCLES 6'h22

`endif

//--- core/cpa_pkg.sv
// Types shared by the cam phase alignment control modules.
// Assumes nothing of its surroundings.
package cpa_pkg;
    // Alignment sequencer states, one-hot
    typedef enum logic [3:0] {
        CPA_IDLE = 4'h1,
        CPA_DIV = 4'h2,
        CPA_CALC = 4'h4,
        CPA_STORE = 4'h8
    } cpa_state_t;
endpackage

//--- core/cpa_div_if.sv
// Interface carrying the quotient request between the top and the divider.
// Assumes one clock domain shared by both modules.
`timescale 1ns/1ps
interface cpa_div_if;
    logic start;
    logic [31:0] num;
    logic [31:0] den;
    logic done;
    logic [31:0] quo;
    // Requesting side
    modport master (output start, output num, output den,
                    input done, input quo);
    // Dividing side
    modport slave (input start, input num, input den,
                   output done, output quo);
endinterface

//--- core/cpa_divider.sv
// Serial restoring divider giving pulses per cam cycle.
// Assumes every change of numerator or denominator comes with a new start.
`timescale 1ns/1ps
module cpa_divider (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Request channel
    cpa_div_if.slave dv
);
    `include "cpa_map.svh"

    logic [63:0] rem_q; // Partial remainder and quotient
    logic [5:0] cnt_q; // Bits left
    logic busy_q;
    logic done_q;

    // ======================================================================
    // One quotient bit per cycle; zero denominator gives all ones
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rem_q <= 64'h0;
            cnt_q <= 6'h0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            // A new request restarts a running division, so a ratio change
            // that lands mid-run is never lost behind a stale quotient
            if (dv.start) begin
                rem_q <= {32'h0, dv.num};
                cnt_q <= 6'h20;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                if (cnt_q == 6'h0) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end else if (rem_q[62:31] >= dv.den) begin
                    rem_q <= {rem_q[62:31] - dv.den, rem_q[30:0], 1'b1};
                    cnt_q <= cnt_q - 6'h1;
                end else begin
                    rem_q <= {rem_q[62:0], 1'b0};
                    cnt_q <= cnt_q - 6'h1;
                end
            end
        end
    end

    assign dv.done = done_q;
    assign dv.quo = rem_q[31:0];
endmodule

//--- core/cpa_align_ctrl.sv
// Cam phase alignment correction logic of a servo drive.
// Assumes the parameter interface strobes writes on i_clk and the trigger
// and master position come from outside this clock domain.
// Functional notes
// - Ratio change clears target at or above quotient
// - Out of range target refused, error flagged
// - Error stored in selected procedure slot
// - Bit 1 launches correction procedure immediately
// - Bit 2 selects cutter or film category
// - Filter zero off, else power-two average
// - Path percent splits forward and backward
// - Shortage stored to slot; slot zero skipped
// - Trigger samples current cam position
`timescale 1ns/1ps
module cpa_align_ctrl (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Parameter write and read port
    input wire logic i_wr,
    input wire logic [15:0] i_addr,
    input wire logic [15:0] i_wdata,
    output logic [15:0] o_rdata,
    // Other drive parameters
    input wire logic i_target_wr,
    input wire logic [31:0] i_target_wdata,
    input wire logic [31:0] i_operation_setting,
    input wire logic [31:0] i_master_pulses_numerator,
    input wire logic [31:0] i_cam_cycles_denominator,
    // Cam side
    input wire logic i_alignment_trigger_input,
    input wire logic [31:0] i_cam_position,
    // Results
    output logic [31:0] o_alignment_target_position,
    output logic o_entry_error,
    output logic o_slot_wr,
    output logic [5:0] o_slot_num,
    output logic [31:0] o_slot_data,
    output logic o_procedure_start,
    output logic o_carry_forward
);
    `include "cpa_map.svh"

    logic [15:0] src_q; // alignment_source_setting
    logic [15:0] msk_q; // master_pulse_masking
    logic [31:0] tgt_q;
    logic [31:0] quo_q; // Pulses per cam cycle
    logic err_q;
    logic [2:0] trg_sync_q;
    logic [31:0] pos_q; // Sampled cam position
    logic [31:0] ratio_n_q;
    logic [31:0] ratio_d_q;
    logic ratio_chg;
    logic trg_rise;
    logic [31:0] acc_q; // Filtered error, same scale as err_sgn
    logic [31:0] err_raw;
    logic [31:0] fwd_lim;
    logic signed [31:0] err_sgn;
    logic signed [31:0] avg_d;
    cpa_pkg::cpa_state_t st_q;
    logic [3:0] filt;
    logic div_start;
    cpa_div_if dv ();

    // ======================================================================
    // Quotient of master pulses over cam cycles
    assign ratio_chg = (ratio_n_q != i_master_pulses_numerator) ||
                       (ratio_d_q != i_cam_cycles_denominator);
    assign div_start = ratio_chg || (st_q == cpa_pkg::CPA_DIV);
    assign dv.start = div_start;
    assign dv.num = i_master_pulses_numerator;
    assign dv.den = i_cam_cycles_denominator;

    cpa_divider u_div (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .dv(dv)
    );

    // Ratio capture and quotient latch
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ratio_n_q <= 32'h0;
            ratio_d_q <= 32'h0;
            quo_q <= 32'hFFFFFFFF;
        end else begin
            ratio_n_q <= i_master_pulses_numerator;
            ratio_d_q <= i_cam_cycles_denominator;
            if (dv.done) begin
                quo_q <= dv.quo;
            end
        end
    end

    // ======================================================================
    // Register writes; bit 3 is stored but steers nothing
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            src_q <= `CPA_RST_SOURCE;
            msk_q <= `CPA_RST_MASKING;
        end else if (i_wr) begin
            if (i_addr == `CPA_OFS_SOURCE) begin
                src_q <= i_wdata;
            end
            if (i_addr == `CPA_OFS_MASKING) begin
                msk_q <= i_wdata;
            end
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        case (i_addr)
            `CPA_OFS_SOURCE: o_rdata = src_q;
            `CPA_OFS_MASKING: o_rdata = msk_q;
            default: o_rdata = 16'h0;
        endcase
    end

    // ======================================================================
    // Target entry and automatic clear on quotient shrink
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tgt_q <= `CPA_RST_TARGET;
            err_q <= 1'b0;
        end else begin
            if (i_target_wr) begin
                if (i_target_wdata >= quo_q) begin
                    err_q <= 1'b1;
                end else begin
                    tgt_q <= i_target_wdata;
                    err_q <= 1'b0;
                end
            end else if (dv.done && tgt_q >= dv.quo) begin
                tgt_q <= 32'h0;
            end
        end
    end

    // ======================================================================
    // Trigger synchroniser; only stage two and three are compared
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            trg_sync_q <= 3'h0;
        end else begin
            trg_sync_q <= {trg_sync_q[1:0], i_alignment_trigger_input};
        end
    end
    assign trg_rise = trg_sync_q[1] && !trg_sync_q[2];

    // ======================================================================
    // Error against target, folded by path share of the cycle
    assign filt = src_q[`CPA_FILT_MSB:`CPA_FILT_LSB];
    assign err_raw = (pos_q >= tgt_q) ? pos_q - tgt_q
                                      : pos_q + quo_q - tgt_q;
    // Forward limit: errors at or above quo_q minus it are corrected forward
    assign fwd_lim = (src_q[`CPA_PATH_MSB:`CPA_PATH_LSB] >= `CPA_PATH_FULL)
        ? quo_q
        : 32'((64'(quo_q) * 64'(src_q[`CPA_PATH_MSB:`CPA_PATH_LSB]))
              / 64'(`CPA_PATH_FULL));
    // Forward correction is positive shortage: slave catches up
    assign err_sgn = (err_raw != 32'h0 && err_raw >= quo_q - fwd_lim)
        ? $signed(quo_q - err_raw) : -$signed(err_raw);
    // Exponential average approximates 2^filt window
    assign avg_d = (filt == 4'h0) ? err_sgn
        : $signed(acc_q) + ((err_sgn - $signed(acc_q)) >>> filt);

    // ======================================================================
    // Alignment sequencer
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_q <= cpa_pkg::CPA_IDLE;
            pos_q <= 32'h0;
            acc_q <= 32'h0;
        end else begin
            case (st_q)
                cpa_pkg::CPA_IDLE: begin
                    if (trg_rise && src_q[`CPA_BIT_ENABLE]) begin
                        pos_q <= i_cam_position;
                        st_q <= cpa_pkg::CPA_DIV;
                    end
                end
                cpa_pkg::CPA_DIV: begin
                    st_q <= cpa_pkg::CPA_CALC; // Refresh quotient
                end
                cpa_pkg::CPA_CALC: begin
                    if (dv.done) begin
                        st_q <= cpa_pkg::CPA_STORE;
                    end
                end
                cpa_pkg::CPA_STORE: begin
                    acc_q <= avg_d; // Filter memory
                    st_q <= cpa_pkg::CPA_IDLE;
                end
                default: st_q <= cpa_pkg::CPA_IDLE;
            endcase
        end
    end

    // ======================================================================
    // Outputs toward the procedure table
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_slot_wr <= 1'b0;
            o_slot_num <= 6'h0;
            o_slot_data <= 32'h0;
            o_procedure_start <= 1'b0;
            o_carry_forward <= 1'b0;
        end else begin
            o_slot_wr <= 1'b0;
            o_procedure_start <= 1'b0;
            if (st_q == cpa_pkg::CPA_STORE) begin
                o_slot_num <= i_operation_setting[`CPA_SLOT_MSB:`CPA_SLOT_LSB];
                o_slot_data <= avg_d;
                o_slot_wr <= (i_operation_setting[`CPA_SLOT_MSB:
                              `CPA_SLOT_LSB] != 6'h0);
                o_procedure_start <= src_q[`CPA_BIT_LAUNCH];
                o_carry_forward <= src_q[`CPA_BIT_FILM];
            end
        end
    end

    assign o_alignment_target_position = tgt_q;
    assign o_entry_error = err_q;

    // ======================================================================
    // Checks
    AST_CLEAR: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        dv.done && !i_target_wr && tgt_q >= dv.quo |=> tgt_q == 32'h0)
        else $error("target not cleared after ratio change");
    AST_REFUSE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        i_target_wr && i_target_wdata >= quo_q
        |=> o_entry_error && $stable(tgt_q))
        else $error("bad target accepted");
    AST_DISABLED: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        st_q == cpa_pkg::CPA_IDLE && trg_rise && !src_q[`CPA_BIT_ENABLE]
        |=> st_q == cpa_pkg::CPA_IDLE)
        else $error("alignment ran while disabled");
    AST_SAMPLE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        st_q == cpa_pkg::CPA_IDLE && trg_rise && src_q[`CPA_BIT_ENABLE]
        |=> pos_q == $past(i_cam_position))
        else $error("cam position not sampled");
    AST_STORE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        st_q == cpa_pkg::CPA_STORE |=> o_slot_data == $past(avg_d))
        else $error("error not stored");
    AST_SLOT0: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_slot_wr |-> o_slot_num != 6'h0)
        else $error("slot zero written");
    AST_LAUNCH: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_procedure_start |-> o_carry_forward == src_q[`CPA_BIT_FILM]
        && $past(st_q) == cpa_pkg::CPA_STORE)
        else $error("launch out of sequence");
    AST_NOFILT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        filt == 4'h0 && st_q == cpa_pkg::CPA_STORE
        |=> o_slot_data == $past(err_sgn))
        else $error("filter active at zero");
    AST_BACK: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        src_q[`CPA_PATH_MSB:`CPA_PATH_LSB] == 8'h0 |-> err_sgn <= 0)
        else $error("forward path at zero share");
endmodule

//--- tb/cpa_sensor_model.sv
// Model of the alignment sensor and the master position source.
// Assumes the bench asks for a trigger by a pulse on i_fire at negedge.
`timescale 1ns/1ps
module cpa_sensor_model (
    // Clock
    input wire logic i_clk,
    // Bench requests
    input wire logic i_fire,
    input wire logic [31:0] i_pos,
    // Lines into the block
    output logic o_trig,
    output logic [31:0] o_pos
);
    // Cycles left of the sensor pulse
    int hold = 0;
    // ==========================================================
    // Sensor pulse
    // Held four cycles so the synchroniser surely sees the rise
    always @(posedge i_clk) begin
        if (i_fire) begin
            hold <= 4;
        end else if (hold > 0) begin
            hold <= hold - 1;
        end
    end
    assign o_trig = (hold > 0);
    // Position stands still around each trigger
    assign o_pos = i_pos;
endmodule

//--- tb/tb_cam_phase_alignment_control.sv
// Self-checking bench for the cam phase alignment control block.
// Assumes the sensor model above and the design files under core.
`timescale 1ns/1ps
module tb_cam_phase_alignment_control;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, twr = 1'b0, fire = 1'b0;
    logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata;
    logic [31:0] tdata = 32'h00000000, op = 32'h00000000;
    logic [31:0] num = 32'h00000001, den = 32'h00000001;
    logic [31:0] pos = 32'h00000000, cpos, target, sdata;
    logic trig, err, swr, start, carry;
    logic [5:0] snum;
    int err_total = 0, tests_run = 0;
    // ==========================================================
    // Clock and watchdog
    initial begin
        forever #2.5 clk = ~clk;
    end
    initial begin
        #200000;
        err_total++;
        summarize();
    end
    cpa_sensor_model model_u (.i_clk(clk), .i_fire(fire), .i_pos(pos),
        .o_trig(trig), .o_pos(cpos));
    cpa_align_ctrl dut_u (.i_clk(clk), .i_reset_n(rst_n), .i_wr(wr),
        .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
        .i_target_wr(twr), .i_target_wdata(tdata),
        .i_operation_setting(op), .i_master_pulses_numerator(num),
        .i_cam_cycles_denominator(den), .i_alignment_trigger_input(trig),
        .i_cam_position(cpos), .o_alignment_target_position(target),
        .o_entry_error(err), .o_slot_wr(swr), .o_slot_num(snum),
        .o_slot_data(sdata), .o_procedure_start(start),
        .o_carry_forward(carry));
    // ==========================================================
    // Shared tasks
    task automatic chk(input string name, input logic [31:0] exp,
            input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic tgt_wr(input logic [31:0] d);
        @(negedge clk);
        tdata = d;
        twr = 1'b1;
        @(negedge clk);
        twr = 1'b0;
    endtask
    // Ratio change, then room for the serial divider to finish
    task automatic ratio(input logic [31:0] n);
        @(negedge clk);
        num = n;
        repeat (50) @(negedge clk);
    endtask
    // One trigger; reports whether a store and a launch were seen
    task automatic fire_once(output logic w, output logic s,
            output logic [5:0] sn, output logic [31:0] sd);
        w = 1'b0;
        s = 1'b0;
        sn = 6'h00;
        sd = 32'h00000000;
        @(negedge clk);
        fire = 1'b1;
        @(negedge clk);
        fire = 1'b0;
        repeat (80) begin
            @(negedge clk);
            if (swr === 1'b1) begin
                w = 1'b1;
                sn = snum;
                sd = sdata;
            end
            if (start === 1'b1) s = 1'b1;
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        addr = 16'h0298;
        #1 chk("source reset", 32'h00000000, {16'h0000, rdata});
        addr = 16'h029A;
        #1 chk("masking reset", 32'h00000000, {16'h0000, rdata});
        addr = 16'h0300;
        #1 chk("unmapped read", 32'h00000000, {16'h0000, rdata});
        chk("target reset", 32'h00000000, target);
    endtask
    task automatic t_entry();
        ratio(32'h00000064);
        tgt_wr(32'h00000064);
        chk("refused error", 32'h00000001, {31'h0, err});
        chk("refused target", 32'h00000000, target);
        tgt_wr(32'h0000000A);
        chk("accepted error", 32'h00000000, {31'h0, err});
        chk("accepted target", 32'h0000000A, target);
    endtask
    task automatic t_align();
        logic w, s;
        logic [5:0] sn;
        logic [31:0] sd;
        // Enabled, launch, backward only, no filter, slot 5
        op = 32'h00000500;
        pos = 32'h0000000D;
        reg_wr(16'h0298, 16'h0003);
        fire_once(w, s, sn, sd);
        chk("store seen", 32'h00000001, {31'h0, w});
        chk("slot number", 32'h00000005, {26'h0, sn});
        chk("backward value", 32'hFFFFFFFD, sd);
        chk("launch seen", 32'h00000001, {31'h0, s});
        chk("cutter carry", 32'h00000000, {31'h0, carry});
        reg_wr(16'h0298, 16'h0001);
        fire_once(w, s, sn, sd);
        chk("manual store", 32'h00000001, {31'h0, w});
        chk("no launch", 32'h00000000, {31'h0, s});
        // Only the reserved bit set: alignment stays off
        reg_wr(16'h0298, 16'h0008);
        fire_once(w, s, sn, sd);
        chk("off store", 32'h00000000, {31'h0, w});
        // Film mode, filter three, slot zero
        op = 32'h00000000;
        reg_wr(16'h0298, 16'h0037);
        addr = 16'h0298;
        #1 chk("source readback", 32'h00000037, {16'h0, rdata});
        fire_once(w, s, sn, sd);
        chk("slot zero store", 32'h00000000, {31'h0, w});
        chk("slot zero launch", 32'h00000001, {31'h0, s});
        chk("film carry", 32'h00000001, {31'h0, carry});
        // Slot five again: filter three pulls the new error in by 1/8
        op = 32'h00000500;
        pos = 32'h0000001A;
        fire_once(w, s, sn, sd);
        chk("filtered value", 32'hFFFFFFFB, sd);
        // Full forward share, filter off: correction runs forward
        reg_wr(16'h0298, 16'h6401);
        fire_once(w, s, sn, sd);
        chk("forward value", 32'h00000054, sd);
    endtask
    task automatic t_ratio();
        tgt_wr(32'h0000001E);
        ratio(32'h00000032);
        chk("target kept", 32'h0000001E, target);
        ratio(32'h0000001E);
        chk("target cleared", 32'h00000000, target);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_reset();
        t_entry();
        t_align();
        t_ratio();
        summarize();
    end
endmodule
